// File: scpb_reg_bank.v
`timescale 1ns/100ps
`include "scpb_defs.vh"

module scpb_reg_bank
#(
  parameter [7:0] DIV2_CTRL_RESET = `SCPB_RST_DIV2_CTRL
)
(
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register access from the serial engine
  input wire reg_wr,
  input wire reg_rd,
  input wire [`SCPB_AW-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg [7:0] reg_shift_byte,
  output reg reg_rd_valid,
  output reg [`SCPB_AW-1:0] reg_next_addr,
  // Serial engine configuration
  output wire long_instruction,
  output wire lsb_first,
  output wire separate_read_pin_select,
  output wire soft_reset_active,
  // Active control registers
  output reg [7:0] div2_ctrl_act_q,
  output reg [7:0] div2_path_act_q,
  output reg [7:0] prescaler_ratio_field,
  output reg [7:0] clkin_act_q,
  output wire duty_correction_disable,
  output reg update_pulse
);

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // One comparator shape serves both the write decode and the readback
  // decode, so the two can never disagree on which address is which.
  function is_addr;
    input [`SCPB_AW-1:0] a;
    input [`SCPB_AW-1:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  reg [7:0] cfg_q;
  reg [7:0] div2_ctrl_buf_q;
  reg [7:0] div2_path_buf_q;
  reg [7:0] prescale_buf_q;
  reg [7:0] clkin_buf_q;
  reg [7:0] update_q;
  reg [7:0] rd_d;
  wire [`SCPB_AW-1:0] next_addr_w;
  wire [7:0] shift_w;
  wire defaults;

  // The configuration bits act at once; only the lower nibble is used, so
  // a badly mirrored upper nibble is stored and read back but does nothing.
  assign long_instruction = cfg_q[`SCPB_CFG_LONG];
  assign lsb_first = cfg_q[`SCPB_CFG_LSB_FIRST];
  assign separate_read_pin_select = cfg_q[`SCPB_CFG_SEP_READ];
  assign soft_reset_active = cfg_q[`SCPB_CFG_SOFT_RST];
  assign duty_correction_disable = div2_path_act_q[`SCPB_DUTY_OFF_BIT];
  // Soft reset reuses the hard reset path for the buffer, update and active registers.
  assign defaults = rst | soft_reset_active;

  // --------------------------------------------------------------------
  // Port configuration
  // --------------------------------------------------------------------
  // Soft reset stays set until the host clears it; the remaining
  // bits are forced to their defaults while it is set.
  always @(posedge clock)
  begin
    if (rst)
      cfg_q <= `SCPB_RST_PORT_CFG;
    else if (reg_wr && is_addr(reg_addr, `SCPB_ADDR_PORT_CFG))
      cfg_q <= reg_wdata;
    else if (soft_reset_active)
      cfg_q <= `SCPB_RST_PORT_CFG |
               (8'h01 << `SCPB_CFG_SOFT_RST);
  end

  // --------------------------------------------------------------------
  // Buffer registers
  // --------------------------------------------------------------------
  // Reserved bits are dropped on the way in, so readback shows only the
  // fields that exist. Writes are refused while soft reset holds.
  always @(posedge clock)
  begin
    if (defaults)
    begin
      div2_ctrl_buf_q <= DIV2_CTRL_RESET;
      div2_path_buf_q <= `SCPB_RST_DIV2_PATH;
      prescale_buf_q <= `SCPB_RST_PRESCALE;
      clkin_buf_q <= `SCPB_RST_CLKIN;
    end
    else if (reg_wr)
    begin
      if (is_addr(reg_addr, `SCPB_ADDR_DIV2_CTRL))
        div2_ctrl_buf_q <= reg_wdata;
      else if (is_addr(reg_addr, `SCPB_ADDR_DIV2_PATH))
        div2_path_buf_q <= reg_wdata & `SCPB_MASK_DIV2_PATH;
      else if (is_addr(reg_addr, `SCPB_ADDR_PRESCALE))
        prescale_buf_q <= reg_wdata & `SCPB_MASK_PRESCALE;
      else if (is_addr(reg_addr, `SCPB_ADDR_CLKIN))
        clkin_buf_q <= reg_wdata & `SCPB_MASK_CLKIN;
    end
  end

  // --------------------------------------------------------------------
  // Update strobe
  // --------------------------------------------------------------------
  // The stored one lasts a single cycle, then clears itself.
  // A second write of one in the next cycle holds the pulse high for one more cycle.
  always @(posedge clock)
  begin
    if (defaults)
      update_q <= `SCPB_RST_UPDATE;
    else if (reg_wr && is_addr(reg_addr, `SCPB_ADDR_UPDATE))
      update_q <= reg_wdata & (8'h01 << `SCPB_UPDATE_BIT);
    else
      update_q <= `SCPB_RST_UPDATE;
  end

  always @*
  begin
    update_pulse = update_q[`SCPB_UPDATE_BIT];
  end

  // --------------------------------------------------------------------
  // Active registers
  // --------------------------------------------------------------------
  // The active copies drive the hardware and move only on the update
  // pulse or a hard or soft reset, all on the same edge, so a half-written setup never shows.
  always @(posedge clock)
  begin
    if (defaults)
    begin
      div2_ctrl_act_q <= DIV2_CTRL_RESET;
      div2_path_act_q <= `SCPB_RST_DIV2_PATH;
      prescaler_ratio_field <= `SCPB_RST_PRESCALE;
      clkin_act_q <= `SCPB_RST_CLKIN;
    end
    else if (update_pulse)
    begin
      div2_ctrl_act_q <= div2_ctrl_buf_q;
      div2_path_act_q <= div2_path_buf_q;
      prescaler_ratio_field <= prescale_buf_q;
      clkin_act_q <= clkin_buf_q;
    end
  end

  // --------------------------------------------------------------------
  // Readback and transfer order
  // --------------------------------------------------------------------
  // Readback always shows the buffer side, not the active copies, so a
  // host can check a setup before it commits it with the update strobe.
  // Unmapped addresses read as zero.
  always @*
  begin
    if (is_addr(reg_addr, `SCPB_ADDR_PORT_CFG))
      rd_d = cfg_q;
    else if (is_addr(reg_addr, `SCPB_ADDR_DIV2_CTRL))
      rd_d = div2_ctrl_buf_q;
    else if (is_addr(reg_addr, `SCPB_ADDR_DIV2_PATH))
      rd_d = div2_path_buf_q;
    else if (is_addr(reg_addr, `SCPB_ADDR_PRESCALE))
      rd_d = prescale_buf_q;
    else if (is_addr(reg_addr, `SCPB_ADDR_CLKIN))
      rd_d = clkin_buf_q;
    else if (is_addr(reg_addr, `SCPB_ADDR_UPDATE))
      rd_d = update_q;
    else
      rd_d = `SCPB_ZERO8;
  end

  scpb_xfer_order u_order
  (
    .cur_addr(reg_addr),
    .data_in(rd_d),
    .lsb_first(lsb_first),
    .next_addr(next_addr_w),
    .shift_byte(shift_w)
  );

  // The next address is latched on every access so the serial engine can
  // step through a multibyte transfer in either direction; it wraps at
  // the ends of the address space.
  always @(posedge clock)
  begin
    if (rst)
    begin
      reg_rdata <= `SCPB_ZERO8;
      reg_shift_byte <= `SCPB_ZERO8;
      reg_rd_valid <= 1'b0;
      reg_next_addr <= {`SCPB_AW{1'b0}};
    end
    else
    begin
      reg_rd_valid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= rd_d;
        reg_shift_byte <= shift_w;
      end
      if (reg_rd || reg_wr)
        reg_next_addr <= next_addr_w;
    end
  end

endmodule

// File: scpb_defs.vh
`ifndef SCPB_DEFS_VH
`define SCPB_DEFS_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define SCPB_AW 10
`define SCPB_ADDR_PORT_CFG 10'h000
`define SCPB_ADDR_DIV2_CTRL 10'h197
`define SCPB_ADDR_DIV2_PATH 10'h198
`define SCPB_ADDR_PRESCALE 10'h1E0
`define SCPB_ADDR_CLKIN 10'h1E1
`define SCPB_ADDR_UPDATE 10'h232

// ----------------------------------------------------------------------
// Port configuration fields
// ----------------------------------------------------------------------
`define SCPB_CFG_LONG 3
`define SCPB_CFG_SOFT_RST 2
`define SCPB_CFG_LSB_FIRST 1
`define SCPB_CFG_SEP_READ 0

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define SCPB_RST_PORT_CFG 8'h18
`define SCPB_RST_DIV2_CTRL 8'h00
`define SCPB_RST_DIV2_PATH 8'h00
`define SCPB_RST_PRESCALE 8'h02
`define SCPB_RST_CLKIN 8'h00
`define SCPB_RST_UPDATE 8'h00
`define SCPB_MASK_DIV2_PATH 8'h03
`define SCPB_MASK_PRESCALE 8'h07
`define SCPB_MASK_CLKIN 8'h1F
`define SCPB_UPDATE_BIT 0
`define SCPB_DUTY_OFF_BIT 0
`define SCPB_ZERO8 8'h00

`endif

// File: scpb_xfer_order.v
`timescale 1ns/100ps
`include "scpb_defs.vh"

module scpb_xfer_order
(
  // Transfer position
  input wire [`SCPB_AW-1:0] cur_addr,
  input wire [7:0] data_in,
  input wire lsb_first,
  // Serial-order results
  output wire [`SCPB_AW-1:0] next_addr,
  output wire [7:0] shift_byte
);

  genvar i;

  assign next_addr = lsb_first ? cur_addr + 1'b1 : cur_addr - 1'b1;

  // Bit 7 leaves first when MSB first; reversed so bit 0 leaves first.
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_rev
      assign shift_byte[i] = lsb_first ? data_in[7-i] : data_in[i];
    end
  endgenerate

endmodule

// File: scpb_host.sv
`timescale 1ns/100ps
module scpb_host
(
  // Clock
  input wire clock,
  // Access toward the bank
  output reg reg_wr,
  output reg reg_rd,
  output reg [9:0] reg_addr,
  output reg [7:0] reg_wdata,
  // Read answer
  input wire [7:0] reg_rdata
);
  initial
  begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
  end

  // Callers pass mirrored configuration bytes with bit 3 set and clear soft
  // reset themselves; released address and data lines show the inverse of the last value.
  task xfer(input w, input [9:0] a, input [7:0] d, output [7:0] q);
  begin
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clock);
    q = reg_rdata;
  end
  endtask
endmodule

// File: scpb_reg_bank_chk.sv
`timescale 1ns/100ps
`include "scpb_defs.vh"
module scpb_reg_bank_chk
(
  // Clock and reset
  input wire clock,
  input wire rst,
  // Access
  input wire reg_wr,
  input wire reg_rd,
  input wire [`SCPB_AW-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  // Results
  input wire [7:0] reg_rdata,
  input wire [7:0] reg_shift_byte,
  input wire reg_rd_valid,
  input wire [`SCPB_AW-1:0] reg_next_addr,
  input wire long_instruction,
  input wire lsb_first,
  input wire separate_read_pin_select,
  input wire soft_reset_active,
  input wire [7:0] prescaler_ratio_field,
  input wire [7:0] clkin_act_q,
  input wire update_pulse
);
  wire [7:0] rdata_rev = {reg_rdata[0], reg_rdata[1], reg_rdata[2],
    reg_rdata[3], reg_rdata[4], reg_rdata[5], reg_rdata[6], reg_rdata[7]};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  chk_rd_valid_follows: assert property (reg_rd_valid == $past(reg_rd))
    else $error("read valid not one cycle after read");
  chk_update_self_clear: assert property (update_pulse &&
    !(reg_wr && reg_addr == `SCPB_ADDR_UPDATE) |=> !update_pulse)
    else $error("update bit did not clear");
  chk_update_set: assert property (reg_wr && reg_wdata[0] &&
    reg_addr == `SCPB_ADDR_UPDATE && !soft_reset_active |=> update_pulse)
    else $error("update bit not set");
  chk_active_hold: assert property (!update_pulse && !soft_reset_active
    |=> $stable({prescaler_ratio_field, clkin_act_q}))
    else $error("active register moved without update");
  chk_soft_defaults: assert property (soft_reset_active |=>
    prescaler_ratio_field == 8'h02 && clkin_act_q == 8'h00 && !update_pulse)
    else $error("soft reset did not restore defaults");
  chk_soft_sticky: assert property (soft_reset_active &&
    !(reg_wr && reg_addr == `SCPB_ADDR_PORT_CFG) |=> soft_reset_active)
    else $error("soft reset bit cleared itself");
  chk_cfg_fields: assert property (
    reg_wr && reg_addr == `SCPB_ADDR_PORT_CFG |=>
    {4'h0, long_instruction, soft_reset_active, lsb_first,
    separate_read_pin_select} == ($past(reg_wdata) & 8'h0F))
    else $error("configuration fields wrong");
  chk_next_addr: assert property ((reg_wr || reg_rd) |=>
    reg_next_addr == ($past(lsb_first) ? $past(reg_addr) + 10'h001
    : $past(reg_addr) - 10'h001))
    else $error("next address wrong");
  chk_shift_order: assert property (reg_rd_valid |->
    reg_shift_byte == ($past(lsb_first) ? rdata_rev : reg_rdata))
    else $error("shift byte order wrong");
endmodule

bind scpb_reg_bank scpb_reg_bank_chk chk_u
(
  .clock, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_shift_byte, .reg_rd_valid, .reg_next_addr, .long_instruction,
  .lsb_first, .separate_read_pin_select, .soft_reset_active,
  .prescaler_ratio_field, .clkin_act_q, .update_pulse
);

// File: tb.sv
`timescale 1ns/100ps
`include "scpb_defs.vh"
module tb;
  reg clock;
  reg rst;
  reg [7:0] d;
  integer fails = 0;
  integer total_checks = 0;
  wire reg_wr, reg_rd, reg_rd_valid, long_instruction, lsb_first;
  wire separate_read_pin_select, soft_reset_active, update_pulse;
  wire [9:0] reg_addr, reg_next_addr;
  wire [7:0] reg_wdata, reg_rdata, reg_shift_byte, prescaler_ratio_field;
  wire [7:0] clkin_act_q, div2_ctrl_act_q, div2_path_act_q;
  wire duty_correction_disable;

  scpb_reg_bank dut_u
  (
    .clock, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_shift_byte, .reg_rd_valid, .reg_next_addr, .long_instruction,
    .lsb_first, .separate_read_pin_select, .soft_reset_active,
    .div2_ctrl_act_q, .div2_path_act_q, .prescaler_ratio_field,
    .clkin_act_q, .duty_correction_disable, .update_pulse
  );
  scpb_host host_u
  (
    .clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata
  );

  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  task check(input [8*6:1] nm, input [9:0] seen, input [9:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask

  task wr(input [9:0] a, input [7:0] v);
  begin
    host_u.xfer(1'h1, a, v, d);
    #1;
  end
  endtask

  task wrap_up;
  begin
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  initial
  begin
    rst = 1'h1;
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    host_u.xfer(1'h0, `SCPB_ADDR_PORT_CFG, 8'h00, d);
    check("cfg", d, 8'h18);
    check("long", long_instruction, 1'h1);
    host_u.xfer(1'h0, `SCPB_ADDR_PRESCALE, 8'h00, d);
    check("pre", d, 8'h02);
    check("next", reg_next_addr, 10'h1DF);
    check("shift", reg_shift_byte, 8'h02);
    wr(`SCPB_ADDR_PRESCALE, 8'h05);
    wr(`SCPB_ADDR_CLKIN, 8'h1F);
    check("act", prescaler_ratio_field, 8'h02);
    wr(`SCPB_ADDR_DIV2_CTRL, 8'hA5);
    wr(`SCPB_ADDR_DIV2_PATH, 8'hFF);
    host_u.xfer(1'h0, `SCPB_ADDR_DIV2_PATH, 8'h00, d);
    check("path", d, 8'h03);
    check("dcc", duty_correction_disable, 1'h0);
    wr(`SCPB_ADDR_UPDATE, 8'h01);
    check("act", prescaler_ratio_field, 8'h05);
    check("clkin", clkin_act_q, 8'h1F);
    check("div2", div2_ctrl_act_q, 8'hA5);
    check("path", div2_path_act_q, 8'h03);
    check("dcc", duty_correction_disable, 1'h1);
    host_u.xfer(1'h0, `SCPB_ADDR_UPDATE, 8'h00, d);
    check("upd", d, 8'h00);
    host_u.xfer(1'h0, 10'h100, 8'h00, d);
    check("unmap", d, 8'h00);
    wr(`SCPB_ADDR_PORT_CFG, 8'hDB);
    check("sep", separate_read_pin_select, 1'h1);
    host_u.xfer(1'h0, `SCPB_ADDR_PRESCALE, 8'h00, d);
    check("next", reg_next_addr, 10'h1E1);
    check("shift", reg_shift_byte, 8'hA0);
    wr(`SCPB_ADDR_PORT_CFG, 8'h3C);
    wr(`SCPB_ADDR_CLKIN, 8'h1F);
    check("act", prescaler_ratio_field, 8'h02);
    check("clkin", clkin_act_q, 8'h00);
    check("div2", div2_ctrl_act_q, `SCPB_RST_DIV2_CTRL);
    check("path", div2_path_act_q, 8'h00);
    check("dcc", duty_correction_disable, 1'h0);
    check("soft", soft_reset_active, 1'h1);
    wr(`SCPB_ADDR_PORT_CFG, 8'h18);
    host_u.xfer(1'h0, `SCPB_ADDR_CLKIN, 8'h00, d);
    check("buf", d, 8'h00);
    check("soft", soft_reset_active, 1'h0);
    wrap_up;
  end

  initial
  begin
    #20000;
    fails = fails + 1;
    wrap_up;
  end
endmodule
